// *** bench/fieldbus_link_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "fieldbus_node_defines.svh"
module fieldbus_link_properties (
    input wire logic                          aclk,
    input wire logic                          aresetn,
    input wire logic                          req_valid,
    input wire logic                          req_ready,
    input wire logic [7:0]                    req_class,
    input wire logic [7:0]                    req_attribute,
    input wire logic [7:0]                    req_value,
    input wire logic                          rsp_valid,
    input var  fieldbus_node_pkg::rsp_status_e rsp_status
);
    // ==========================================
    // helper: last taken request
    logic       took;
    logic [7:0] cls;
    logic [7:0] attr;
    logic [7:0] val;
    always_ff @(posedge aclk) begin
        took <= aresetn && req_valid && req_ready;
        if (req_valid && req_ready) begin
            cls  <= req_class;
            attr <= req_attribute;
            val  <= req_value;
        end
    end
    wire is_link = rsp_valid && (cls == `CLASS_LINK);
    // ==========================================
    // properties
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_take;
        req_valid && req_ready;
    endsequence
    sequence s_answer;
        rsp_valid ##1 !rsp_valid;
    endsequence
    chk_rsp_timing: assert property (s_take |=> s_answer)
        else $error("answer not one cycle after take");
    chk_ready_idle: assert property (req_ready == !rsp_valid)
        else $error("req_ready not inverse of rsp_valid");
    chk_req_drop: assert property (s_take |=> !req_valid)
        else $error("request not released after take");
    chk_req_hold: assert property (s_take |=> $stable({req_class, req_attribute, req_value}))
        else $error("request changed before answer");
    chk_no_stray: assert property (rsp_valid |-> took)
        else $error("answer without request");
    chk_save_ok: assert property (rsp_valid && cls == `CLASS_STORE && attr == `ATTR_SAVE
        |-> rsp_status == fieldbus_node_pkg::rsp_ok)
        else $error("save not accepted");
    chk_unknown_obj: assert property (rsp_valid && cls != `CLASS_LINK && cls != `CLASS_STORE
        |-> rsp_status == fieldbus_node_pkg::rsp_unknown)
        else $error("unknown object not reported");
    chk_addr_range: assert property (is_link && attr == `ATTR_ADDRESS && val > `ADDR_MAX
        |-> rsp_status inside {fieldbus_node_pkg::rsp_refused,
                               fieldbus_node_pkg::rsp_bad_value})
        else $error("address above range accepted");
    chk_rate_range: assert property (is_link && attr == `ATTR_RATE && val > `RATE_CODE_MAX
        |-> rsp_status inside {fieldbus_node_pkg::rsp_refused,
                               fieldbus_node_pkg::rsp_bad_value})
        else $error("rate code above range accepted");
endmodule : fieldbus_link_properties
`default_nettype wire

// *** bench/fieldbus_node_status_config_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "fieldbus_node_defines.svh"
module fieldbus_node_status_config_tb_top;
    logic aclk = 0, aresetn = 0;
    logic [3:0] tens = 4'h6, units = 4'h4, rsw = 4'h3;
    logic nac = 0, brc = 0, save = 0, rst_cmd = 0;
    logic [5:0] nav = 6'h00;
    logic [9:0] kbit = 10'h000, st = 10'h000;
    logic [5:0] node_address;
    logic [1:0] bit_rate_code, bresp, rresp;
    logic led_green, led_red, awready, wready, bvalid, arready, rvalid;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    int fails = 0, total_checks = 0;
    always #2 aclk = ~aclk;
    fieldbus_link_if fieldbus_link_if_i ();
    fieldbus_node_device #(.BLINK_HALF_CYCLES(8)) fieldbus_node_device_i (
        .aclk(aclk), .aresetn(aresetn), .link(fieldbus_link_if_i.device_end),
        .tens_digit_switch(tens), .units_digit_switch(units), .bit_rate_switch(rsw),
        .node_address_command(nac), .node_address_value(nav), .bit_rate_command(brc),
        .bit_rate_kbit(kbit), .save_command(save), .restart_command(rst_cmd),
        .online(st[9]), .duplicate_node_address_check(st[8]), .duplicate_address_found(st[7]),
        .connections_established(st[6]), .master_allocated(st[5]), .config_bad(st[4]),
        .recoverable_fault(st[3]), .io_connection_waiting(st[2]),
        .unrecoverable_fault(st[1]), .bus_off(st[0]), .node_address(node_address),
        .bit_rate_code(bit_rate_code), .led_green(led_green), .led_red(led_red));
    fieldbus_master_ctrl fieldbus_master_ctrl_i (
        .aclk(aclk), .aresetn(aresetn), .link(fieldbus_link_if_i.master_end),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    fieldbus_link_properties fieldbus_link_properties_i (
        .aclk(aclk), .aresetn(aresetn), .req_valid(fieldbus_link_if_i.req_valid),
        .req_ready(fieldbus_link_if_i.req_ready), .req_class(fieldbus_link_if_i.req_class),
        .req_attribute(fieldbus_link_if_i.req_attribute),
        .req_value(fieldbus_link_if_i.req_value), .rsp_valid(fieldbus_link_if_i.rsp_valid),
        .rsp_status(fieldbus_link_if_i.rsp_status));
    // ==========================================
    // shared tasks
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task stop_test;
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test
    task axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw_done, w_done;
        aw_done = 0;
        w_done = 0;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && awready === 1'b1) begin aw_done = 1; awvalid <= 0; end
            if (!w_done && wready === 1'b1) begin w_done = 1; wvalid <= 0; end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 0;
    endtask : axi_write
    task axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 0;
    endtask : axi_read
    task net_cmd(input logic [7:0] c, input logic [7:0] at, input logic [7:0] v,
                 input logic [1:0] exp);
        logic [1:0] r;
        logic [31:0] d;
        int n;
        axi_write(`REG_CMD, {8'h00, c, at, v}, r);
        check(r, `RESP_OKAY);
        n = 0;
        do begin axi_read(`REG_STATUS, d, r); n++; end while (!d[3] && n < 50);
        check(d[3], 1'b1);
        check(d[2:1], exp);
    endtask : net_cmd
    task restart_check(input logic [5:0] a, input logic [1:0] rc);
        @(posedge aclk) rst_cmd <= 1;
        @(posedge aclk) rst_cmd <= 0;
        repeat (4) @(posedge aclk);
        check(node_address, a);
        check(bit_rate_code, rc);
    endtask : restart_check
    // ==========================================
    // scenarios
    task t_leds;
        static logic [9:0] cond [9] = '{10'h000, 10'h360, 10'h320, 10'h370, 10'h364, 10'h369,
                                        10'h380, 10'h260, 10'h324};
        static logic [3:0] exp [9] = '{4'h5, 4'h9, 4'hd, 4'hd, 4'h7, 4'h6, 4'h6, 4'h5, 4'h7};
        logic [3:0] seen;
        for (int i = 0; i < 9; i++) begin
            @(posedge aclk) st <= cond[i];
            repeat (3) @(posedge aclk);
            seen = 4'h0;
            repeat (40) begin
                @(posedge aclk);
                seen |= {led_green === 1'b1, led_green === 1'b0, led_red === 1'b1,
                         led_red === 1'b0};
            end
            check(seen, exp[i]);
        end
    endtask : t_leds
    task t_terminal;
        @(posedge aclk) begin nac <= 1; nav <= 6'h05; brc <= 1; kbit <= `KBIT_250; end
        @(posedge aclk) begin nac <= 0; brc <= 0; end
        restart_check(6'h3f, 2'h0);
        @(posedge aclk) begin nac <= 1; nav <= 6'h05; brc <= 1; kbit <= `KBIT_250; end
        @(posedge aclk) begin nac <= 0; brc <= 0; save <= 1; end
        @(posedge aclk) save <= 0;
        repeat (3) @(posedge aclk);
        check(node_address, 6'h3f);
        restart_check(6'h05, `RATE_CODE_250);
    endtask : t_terminal
    task t_network;
        logic [31:0] d;
        logic [1:0] r;
        net_cmd(`CLASS_LINK, `ATTR_ADDRESS, 8'h11, 2'h0);
        net_cmd(`CLASS_LINK, `ATTR_RATE, 8'h02, 2'h0);
        net_cmd(`CLASS_LINK, `ATTR_ADDRESS, 8'h40, 2'h2);
        net_cmd(`CLASS_LINK, `ATTR_RATE, 8'h03, 2'h2);
        net_cmd(8'h07, `ATTR_ADDRESS, 8'h01, 2'h3);
        restart_check(6'h05, `RATE_CODE_250);
        net_cmd(`CLASS_LINK, `ATTR_ADDRESS, 8'h11, 2'h0);
        net_cmd(`CLASS_LINK, `ATTR_RATE, 8'h02, 2'h0);
        net_cmd(`CLASS_STORE, `ATTR_SAVE, 8'h00, 2'h0);
        check(node_address, 6'h05);
        restart_check(6'h11, `RATE_CODE_500);
        axi_read(4'h8, d, r);
        check(d, 32'h0);
        check(r, `RESP_SLVERR);
        axi_write(4'h8, 32'h0, r);
        check(r, `RESP_SLVERR);
    endtask : t_network
    task t_switches;
        static logic [3:0] tv [3] = '{4'h0, 4'h2, 4'h6};
        static logic [3:0] uv [3] = '{4'h0, 4'h7, 4'h3};
        for (int i = 0; i < 3; i++) begin
            @(posedge aclk) begin tens <= tv[i]; units <= uv[i]; rsw <= 4'(i); end
            restart_check(6'(tv[i] * 10 + uv[i]), 2'(i));
        end
        net_cmd(`CLASS_LINK, `ATTR_ADDRESS, 8'h11, 2'h1);
        net_cmd(`CLASS_LINK, `ATTR_RATE, 8'h00, 2'h1);
    endtask : t_switches
    // ==========================================
    // main sequence and watchdog
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        repeat (3) @(posedge aclk);
        check({node_address, bit_rate_code}, {`STORED_ADDR_RESET, `STORED_RATE_RESET});
        t_leds();
        t_terminal();
        t_network();
        t_switches();
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        stop_test();
    end
endmodule : fieldbus_node_status_config_tb_top
`default_nettype wire

// *** pkg/fieldbus_link_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface fieldbus_link_if;
    logic                              req_valid;
    logic                              req_ready;
    logic [7:0]                        req_class;
    logic [7:0]                        req_attribute;
    logic [7:0]                        req_value;
    logic                              rsp_valid;
    fieldbus_node_pkg::rsp_status_e    rsp_status;

    modport device_end (
        input  req_valid,
        output req_ready,
        input  req_class,
        input  req_attribute,
        input  req_value,
        output rsp_valid,
        output rsp_status
    );

    modport master_end (
        output req_valid,
        input  req_ready,
        output req_class,
        output req_attribute,
        output req_value,
        input  rsp_valid,
        input  rsp_status
    );
endinterface : fieldbus_link_if
`default_nettype wire

// *** pkg/fieldbus_node_defines.svh ***
`ifndef FIELDBUS_NODE_DEFINES_SVH
`define FIELDBUS_NODE_DEFINES_SVH
// ==========================================
// timing
`define CLK_MHZ             250
`define BLINK_HALF_MS       500
`define BLINK_HALF_CYCLES   (`BLINK_HALF_MS * `CLK_MHZ * 1000)
// ==========================================
// switch and parameter limits
`define DIGIT_MAX           4'h9
`define DIGIT_WEIGHT        8'h0a
`define ADDR_MAX            8'h3f
`define RATE_SWITCH_MAX     4'h2
`define RATE_CODE_MAX       8'h02
`define KBIT_125            10'h07d
`define KBIT_250            10'h0fa
`define KBIT_500            10'h1f4
`define RATE_CODE_125       2'h0
`define RATE_CODE_250       2'h1
`define RATE_CODE_500       2'h2
`define STORED_ADDR_RESET   6'h3f
`define STORED_RATE_RESET   2'h0
// ==========================================
// network objects
`define CLASS_LINK          8'h03
`define ATTR_ADDRESS        8'h01
`define ATTR_RATE           8'h02
`define CLASS_STORE         8'h25
`define ATTR_SAVE           8'h65
// ==========================================
// controller register map
`define REG_CMD             4'h0
`define REG_STATUS          4'h4
`define CMD_VALUE_LSB       0
`define CMD_ATTR_LSB        8
`define CMD_CLASS_LSB       16
`define STATUS_BUSY_BIT     0
`define STATUS_CODE_LSB     1
`define STATUS_DONE_BIT     3
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2
`endif

// *** pkg/fieldbus_node_pkg.sv ***
package fieldbus_node_pkg;
    // ==========================================
    // answer to a network object request
    typedef enum logic [1:0] {
        rsp_ok,
        rsp_refused,
        rsp_bad_value,
        rsp_unknown
    } rsp_status_e;

    typedef enum logic [2:0] {
        led_off,
        led_green,
        led_blink_green,
        led_blink_red,
        led_red
    } led_state_e;

    typedef enum logic [1:0] {
        ms_idle,
        ms_request,
        ms_wait
    } master_state_e;
endpackage : fieldbus_node_pkg

// *** rtl/blink_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
module blink_timer #(
    parameter int unsigned HALF_CYCLES = 125000000
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    output logic      phase
);
    logic [31:0] count;
    wire         wrap = (count == 32'(HALF_CYCLES - 1));

    // ==========================================
    // free running half period counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= 32'h0;
            phase <= 1'b0;
        end else begin
            count <= wrap ? 32'h0 : count + 32'h1;
            phase <= wrap ? ~phase : phase;
        end
    end
endmodule : blink_timer
`default_nettype wire

// *** rtl/fieldbus_master_ctrl.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "fieldbus_node_defines.svh"
module fieldbus_master_ctrl (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    fieldbus_link_if.master_end link,
    input  wire logic [3:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [3:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready
);
    fieldbus_node_pkg::master_state_e state;
    fieldbus_node_pkg::rsp_status_e   last_status;
    logic        aw_held;
    logic        w_held;
    logic [3:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic [31:0] cmd;
    logic        done;

    // ==========================================
    // bus decode
    wire aw_take   = awvalid && awready;
    wire w_take    = wvalid && wready;
    wire ar_take   = arvalid && arready;
    wire do_write  = aw_held && w_held && !bvalid;
    wire wr_cmd    = (wr_addr == `REG_CMD);
    wire wr_ok     = wr_cmd || (wr_addr == `REG_STATUS);
    wire busy      = (state != fieldbus_node_pkg::ms_idle);
    wire launch    = do_write && wr_cmd && !busy;
    wire rd_status = ar_take && (araddr == `REG_STATUS);
    wire rd_ok     = (araddr == `REG_CMD) || (araddr == `REG_STATUS);
    wire [31:0] status_word = {28'h0, done, last_status, busy};
    wire [31:0] merged_cmd;

    for (genvar i = 0; i < 4; i++) begin : g_lane
        assign merged_cmd[8*i +: 8] = wr_strb[i] ? wr_data[8*i +: 8] : cmd[8*i +: 8];
    end

    assign awready = !aw_held && !bvalid;
    assign wready  = !w_held && !bvalid;
    assign arready = !rvalid;

    assign link.req_valid     = (state == fieldbus_node_pkg::ms_request);
    assign link.req_class     = cmd[`CMD_CLASS_LSB +: 8];
    assign link.req_attribute = cmd[`CMD_ATTR_LSB +: 8];
    assign link.req_value     = cmd[`CMD_VALUE_LSB +: 8];

    // ==========================================
    // write channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            wr_addr <= 4'h0;
            wr_data <= 32'h0;
            wr_strb <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= `RESP_OKAY;
        end else begin
            aw_held <= do_write ? 1'b0 : (aw_held || aw_take);
            w_held  <= do_write ? 1'b0 : (w_held || w_take);
            wr_addr <= aw_take ? awaddr : wr_addr;
            wr_data <= w_take ? wdata : wr_data;
            wr_strb <= w_take ? wstrb : wr_strb;
            bvalid  <= do_write || (bvalid && !bready);
            bresp   <= do_write ? (wr_ok ? `RESP_OKAY : `RESP_SLVERR) : bresp;
        end
    end

    // ==========================================
    // read channel, status read clears done unless set again
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0;
            rresp  <= `RESP_OKAY;
        end else begin
            rvalid <= ar_take || (rvalid && !rready);
            if (ar_take) begin
                rdata <= rd_status ? status_word : ((araddr == `REG_CMD) ? cmd : 32'h0);
                rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    // ==========================================
    // request sequencer: the node stores, a save plus restart applies
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state       <= fieldbus_node_pkg::ms_idle;
            cmd         <= 32'h0;
            last_status <= fieldbus_node_pkg::rsp_ok;
            done        <= 1'b0;
        end else begin
            cmd  <= launch ? merged_cmd : cmd;
            done <= (link.rsp_valid && state == fieldbus_node_pkg::ms_wait) ||
                    (done && !rd_status);
            case (state)
                fieldbus_node_pkg::ms_idle: begin
                    if (launch) begin
                        state <= fieldbus_node_pkg::ms_request;
                    end
                end
                fieldbus_node_pkg::ms_request: begin
                    if (link.req_ready) begin
                        state <= fieldbus_node_pkg::ms_wait;
                    end
                end
                fieldbus_node_pkg::ms_wait: begin
                    if (link.rsp_valid) begin
                        last_status <= link.rsp_status;
                        state       <= fieldbus_node_pkg::ms_idle;
                    end
                end
                default: state <= fieldbus_node_pkg::ms_idle;
            endcase
        end
    end
endmodule : fieldbus_master_ctrl
`default_nettype wire

// *** rtl/fieldbus_node_device.sv ***
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "fieldbus_node_defines.svh"
module fieldbus_node_device #(
    parameter int unsigned BLINK_HALF_CYCLES = `BLINK_HALF_CYCLES
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    fieldbus_link_if.device_end link,
    input  wire logic [3:0] tens_digit_switch,
    input  wire logic [3:0] units_digit_switch,
    input  wire logic [3:0] bit_rate_switch,
    input  wire logic       node_address_command,
    input  wire logic [5:0] node_address_value,
    input  wire logic       bit_rate_command,
    input  wire logic [9:0] bit_rate_kbit,
    input  wire logic       save_command,
    input  wire logic       restart_command,
    input  wire logic       online,
    input  wire logic       duplicate_node_address_check,
    input  wire logic       duplicate_address_found,
    input  wire logic       connections_established,
    input  wire logic       master_allocated,
    input  wire logic       config_bad,
    input  wire logic       recoverable_fault,
    input  wire logic       io_connection_waiting,
    input  wire logic       unrecoverable_fault,
    input  wire logic       bus_off,
    output logic [5:0]      node_address,
    output logic [1:0]      bit_rate_code,
    output logic            led_green,
    output logic            led_red
);
    // ==========================================
    // helpers
    function automatic logic [7:0] digits_to_address(input logic [3:0] tens,
                                                     input logic [3:0] units);
        if (tens > `DIGIT_MAX || units > `DIGIT_MAX) begin
            return 8'hff;
        end
        return 8'(8'(tens) * `DIGIT_WEIGHT) + 8'(units);
    endfunction : digits_to_address

    function automatic logic [2:0] kbit_to_code(input logic [9:0] kbit);
        case (kbit)
            `KBIT_125: return {1'b1, `RATE_CODE_125};
            `KBIT_250: return {1'b1, `RATE_CODE_250};
            `KBIT_500: return {1'b1, `RATE_CODE_500};
            default:   return 3'h0;
        endcase
    endfunction : kbit_to_code

    // ==========================================
    // switch decode
    wire [7:0] switch_address    = digits_to_address(tens_digit_switch, units_digit_switch);
    wire       address_on_switch = (switch_address <= `ADDR_MAX);
    wire       rate_on_switch    = (bit_rate_switch <= `RATE_SWITCH_MAX);

    // ==========================================
    // stored parameters: pending copy and saved copy
    logic [5:0] pending_address;
    logic [1:0] pending_rate;
    logic [5:0] saved_address;
    logic [1:0] saved_rate;
    logic       boot;

    // ==========================================
    // network request decode
    logic                           rsp_valid;
    fieldbus_node_pkg::rsp_status_e rsp_status;

    wire link_take = link.req_valid && link.req_ready;
    wire hit_link  = (link.req_class == `CLASS_LINK);
    wire hit_addr  = hit_link && (link.req_attribute == `ATTR_ADDRESS);
    wire hit_rate  = hit_link && (link.req_attribute == `ATTR_RATE);
    wire hit_save  = (link.req_class == `CLASS_STORE) && (link.req_attribute == `ATTR_SAVE);
    wire addr_bad  = (link.req_value > `ADDR_MAX);
    wire rate_bad  = (link.req_value > `RATE_CODE_MAX);

    wire fieldbus_node_pkg::rsp_status_e next_rsp_status =
        hit_addr ? (address_on_switch ? fieldbus_node_pkg::rsp_refused :
                    addr_bad ? fieldbus_node_pkg::rsp_bad_value :
                    fieldbus_node_pkg::rsp_ok) :
        hit_rate ? (rate_on_switch ? fieldbus_node_pkg::rsp_refused :
                    rate_bad ? fieldbus_node_pkg::rsp_bad_value :
                    fieldbus_node_pkg::rsp_ok) :
        hit_save ? fieldbus_node_pkg::rsp_ok : fieldbus_node_pkg::rsp_unknown;

    wire request_ok = (next_rsp_status == fieldbus_node_pkg::rsp_ok);
    wire net_addr   = link_take && hit_addr && request_ok;
    wire net_rate   = link_take && hit_rate && request_ok;
    wire net_save   = link_take && hit_save;

    // ==========================================
    // terminal decode
    wire [2:0] term_rate = kbit_to_code(bit_rate_kbit);
    wire term_addr = node_address_command && !address_on_switch;
    wire term_rate_ok = bit_rate_command && term_rate[2] && !rate_on_switch;
    wire do_save = save_command || net_save;

    assign link.req_ready  = !rsp_valid;
    assign link.rsp_valid  = rsp_valid;
    assign link.rsp_status = rsp_status;

    // ==========================================
    // link answer, one cycle after the request is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rsp_valid  <= 1'b0;
            rsp_status <= fieldbus_node_pkg::rsp_ok;
        end else begin
            rsp_valid  <= link_take;
            rsp_status <= link_take ? next_rsp_status : rsp_status;
        end
    end

    // ==========================================
    // pending parameters, network write wins over terminal
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending_address <= `STORED_ADDR_RESET;
            pending_rate    <= `STORED_RATE_RESET;
        end else begin
            if (net_addr) begin
                pending_address <= link.req_value[5:0];
            end else if (term_addr) begin
                pending_address <= node_address_value;
            end
            if (net_rate) begin
                pending_rate <= link.req_value[1:0];
            end else if (term_rate_ok) begin
                pending_rate <= term_rate[1:0];
            end
        end
    end

    // ==========================================
    // saved copy, only written by a save
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            saved_address <= `STORED_ADDR_RESET;
            saved_rate    <= `STORED_RATE_RESET;
        end else if (do_save) begin
            saved_address <= pending_address;
            saved_rate    <= pending_rate;
        end
    end

    // ==========================================
    // active address and rate, loaded at boot only
    wire [5:0] next_node_address = address_on_switch ? switch_address[5:0]
                                                     : saved_address;
    wire [1:0] next_bit_rate_code = rate_on_switch ? bit_rate_switch[1:0]
                                                   : saved_rate;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            boot          <= 1'b1;
            node_address  <= `STORED_ADDR_RESET;
            bit_rate_code <= `STORED_RATE_RESET;
        end else begin
            boot <= restart_command;
            if (boot) begin
                node_address  <= next_node_address;
                bit_rate_code <= next_bit_rate_code;
            end
        end
    end

    // ==========================================
    // indicator
    logic blink_phase;

    blink_timer #(
        .HALF_CYCLES (BLINK_HALF_CYCLES)
    ) u_blink (
        .aclk    (aclk),
        .aresetn (aresetn),
        .phase   (blink_phase)
    );

    wire node_online = online && duplicate_node_address_check && !duplicate_address_found;
    wire fatal       = unrecoverable_fault || bus_off || duplicate_address_found;
    wire minor       = recoverable_fault || io_connection_waiting;
    wire not_ready   = !connections_established || !master_allocated || config_bad;

    // severity order: red, dark, blinking red, blinking green, green
    wire fieldbus_node_pkg::led_state_e led_state =
        fatal        ? fieldbus_node_pkg::led_red :
        !node_online ? fieldbus_node_pkg::led_off :
        minor        ? fieldbus_node_pkg::led_blink_red :
        not_ready    ? fieldbus_node_pkg::led_blink_green :
                       fieldbus_node_pkg::led_green;

    logic next_led_green;
    logic next_led_red;

    always_comb begin
        next_led_green = 1'b0;
        next_led_red   = 1'b0;
        case (led_state)
            fieldbus_node_pkg::led_green:       next_led_green = 1'b1;
            fieldbus_node_pkg::led_blink_green: next_led_green = blink_phase;
            fieldbus_node_pkg::led_blink_red:   next_led_red   = blink_phase;
            fieldbus_node_pkg::led_red:         next_led_red   = 1'b1;
            default: begin
                next_led_green = 1'b0;
                next_led_red   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            led_green <= 1'b0;
            led_red   <= 1'b0;
        end else begin
            led_green <= next_led_green;
            led_red   <= next_led_red;
        end
    end
endmodule : fieldbus_node_device
`default_nettype wire
